// ---- hdl/dac_serial_map.vh ----
// constants for the serial-controlled 32-channel converter core
`ifndef DAC_SERIAL_MAP_VH
`define DAC_SERIAL_MAP_VH
`define WORD_BITS 32
`define WORD_COUNT 6'h20
`define DATA_BITS 14
`define CNT_BITS 6
`define CHAN_COUNT 32
`define BANK_SIZE 16
`define CMD_MSB 31
`define CMD_LSB 28
`define TGT_MSB 27
`define TGT_LSB 22
`define DAT_MSB 21
`define DAT_LSB 8
`define SUB_MSB 7
`define SUB_LSB 6
`define CMD_WRITE_INPUT 4'h1
`define CMD_LOAD 4'h2
`define CMD_WRITE_OFFSET_DAC 4'h3
`define CMD_WRITE_THROUGH 4'h4
`define CMD_WRITE_GAIN 4'h5
`define CMD_WRITE_CAL_OFFSET 4'h6
`define CMD_READ_INPUT 4'h8
`define SEL_BANK0 2'h0
`define SEL_BANK1 2'h1
`define SEL_PAIR 2'h2
`define SEL_SPECIAL 2'h3
`define IDX_OFFSET_DAC 4'h0
`define IDX_ALL 4'hf
`define DSP_MAX_BITS 6'h10
`define RESET_CODE 14'h0000
`define OFFSET_DAC_RESET 14'h0000
`endif

// ---- hdl/serial_shifter.v ----
// serial shift register with falling-edge capture and readback output
`timescale 1ns/1ps
module serial_shifter
(
   input wire clk,
   input wire reset_n,
   input wire fall,
   input wire active,
   input wire start,
   input wire din,
   input wire load,
   input wire [31:0] load_word,
   output reg [31:0] word,
   output reg [5:0] count,
   output reg dout
);
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         word <= 32'h00000000;
         count <= 6'h00;
         dout <= 1'b0;
      end
      else if (load)
      begin
         word <= load_word;
         dout <= load_word[31];
      end
      else if (start)
         count <= 6'h00;
      else if (active && fall)
      begin
         word <= {word[30:0], din};
         dout <= word[30];
         if (count != 6'h3f)
            count <= count + 6'h01;
      end
   end
endmodule

// ---- hdl/dac_serial_update_control.v ----
// serial command decoder, channel registers and load control
`timescale 1ns/1ps
`include "dac_serial_map.vh"
// How it works
// - serial input bits are captured on falling serial clock edges
// - serial output shifts on falling edges, most significant bit first
// - output line carries shifted-through data for chaining or readback
// - mode pin low selects dsp framing, high selects spi framing
// - chip select active low; transfers only while it is low
// - load input low copies all channel input registers to output registers, not offset
// - reset input low repeats power-on initialisation, except shifter and pin synchronisers, without serial clock
// - each of 32 channels has 14-bit input and output stages
// - transfer one channel or all, by command or load input
// - per-channel offset and gain registers applied to channel data
// - two banks of 16; channel n pairs with channel n+16
// - word: 4 command, 6 target, 14 data, 2 zero, 6 spare bits
// - target top bits pick bank 0, bank 1, pair, or special
// - load command 0010 with target 111111 updates all, not offset
module dac_serial_update_control
(
   input wire clk,
   input wire reset_n,
   input wire sclk,
   input wire chip_select_n,
   input wire din,
   input wire spi_mode,
   input wire load_outputs_n,
   input wire device_reset_n,
   input wire [4:0] monitor_channel,
   output wire dout,
   output reg [13:0] monitor_code,
   output reg [13:0] offset_dac_code,
   output reg word_accepted,
   output reg framing_error
);
   // ==========================================
   // pin synchronisers
   reg [1:0] sclk_s;
   reg [1:0] cs_s;
   reg [1:0] din_s;
   reg [1:0] mode_s;
   reg [1:0] ld_s;
   reg [1:0] rst_s;
   reg sclk_d;
   reg cs_d;
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         sclk_s <= 2'h0;
         cs_s <= 2'h3;
         din_s <= 2'h0;
         mode_s <= 2'h0;
         ld_s <= 2'h3;
         rst_s <= 2'h3;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end
      else
      begin
         sclk_s <= {sclk_s[0], sclk};
         cs_s <= {cs_s[0], chip_select_n};
         din_s <= {din_s[0], din};
         mode_s <= {mode_s[0], spi_mode};
         ld_s <= {ld_s[0], load_outputs_n};
         rst_s <= {rst_s[0], device_reset_n};
         sclk_d <= sclk_s[1];
         cs_d <= cs_s[1];
      end
   end
   wire sclk_fall = sclk_d & ~sclk_s[1];
   wire cs_fall = cs_d & ~cs_s[1];
   wire cs_rise = ~cs_d & cs_s[1];
   wire in_frame = ~cs_s[1];
   wire dev_reset = ~rst_s[1];
   // ==========================================
   // shifter
   wire [31:0] word;
   wire [5:0] count;
   reg readback_load;
   reg [31:0] readback_word;
   serial_shifter shifter
   (
      .clk(clk),
      .reset_n(reset_n),
      .fall(sclk_fall),
      .active(in_frame),
      .start(cs_fall),
      .din(din_s[1]),
      .load(readback_load),
      .load_word(readback_word),
      .word(word),
      .count(count),
      .dout(dout)
   );
   // ==========================================
   // channel storage
   reg [13:0] input_reg [0:31];
   reg [13:0] output_reg [0:31];
   reg [13:0] gain_reg [0:31];
   reg [13:0] cal_offset_reg [0:31];
   reg [13:0] offset_dac_input;
   // dsp framing collects words across several short chip select lows
   reg [5:0] dsp_total;
   reg [5:0] low_bits;
   wire [3:0] cmd = word[`CMD_MSB:`CMD_LSB];
   wire [5:0] tgt = word[`TGT_MSB:`TGT_LSB];
   wire [13:0] data = word[`DAT_MSB:`DAT_LSB];
   wire [1:0] sel = tgt[5:4];
   wire [3:0] idx = tgt[3:0];
   wire sub_ok = word[`SUB_MSB:`SUB_LSB] == 2'h0;
   wire full_word = mode_s[1] ? (count >= `WORD_COUNT)
      : (dsp_total >= `WORD_COUNT);
   wire take = cs_rise & full_word & sub_ok;
   // calibrated code: gain trims the upper span, offset adds
   function [13:0] calibrate;
      input [13:0] code;
      input [13:0] gain;
      input [13:0] offs;
      reg [27:0] prod;
      begin
         prod = code * ({1'b0, gain[12:0]} + 14'h2000);
         calibrate = prod[26:13] + offs;
      end
   endfunction
   function hits;
      input [1:0] s;
      input [3:0] i;
      input [4:0] ch;
      begin
         hits = ((s == `SEL_BANK0) && (ch == {1'b0, i}))
            || ((s == `SEL_BANK1) && (ch == {1'b1, i}))
            || ((s == `SEL_PAIR) && (ch[3:0] == i));
      end
   endfunction
   integer n;
   always @(posedge clk)
   begin
      word_accepted <= 1'b0;
      readback_load <= 1'b0;
      if (!reset_n || dev_reset)
      begin
         for (n = 0; n < `CHAN_COUNT; n = n + 1)
         begin
            input_reg[n] <= `RESET_CODE;
            output_reg[n] <= `RESET_CODE;
            gain_reg[n] <= `RESET_CODE;
            cal_offset_reg[n] <= `RESET_CODE;
         end
         offset_dac_input <= `OFFSET_DAC_RESET;
         offset_dac_code <= `OFFSET_DAC_RESET;
         dsp_total <= 6'h00;
         low_bits <= 6'h00;
         framing_error <= 1'b0;
         readback_word <= 32'h00000000;
      end
      else
      begin
         if (cs_fall)
            low_bits <= 6'h00;
         else if (in_frame && sclk_fall)
         begin
            low_bits <= low_bits + 6'h01;
            if (!mode_s[1] && low_bits >= `DSP_MAX_BITS)
               framing_error <= 1'b1;
            if (!mode_s[1] && dsp_total < `WORD_COUNT)
               dsp_total <= dsp_total + 6'h01;
         end
         if (cs_rise && (mode_s[1] || dsp_total >= `WORD_COUNT))
            dsp_total <= 6'h00;
         if (!ld_s[1])
         begin
            for (n = 0; n < `CHAN_COUNT; n = n + 1)
               output_reg[n] <= calibrate(input_reg[n], gain_reg[n],
                  cal_offset_reg[n]);
         end
         if (take)
         begin
            word_accepted <= 1'b1;
            if (sel == `SEL_SPECIAL)
            begin
               if (cmd == `CMD_LOAD && idx == `IDX_ALL)
               begin
                  for (n = 0; n < `CHAN_COUNT; n = n + 1)
                     output_reg[n] <= calibrate(input_reg[n],
                        gain_reg[n], cal_offset_reg[n]);
               end
               else if (cmd == `CMD_WRITE_OFFSET_DAC
                  && idx == `IDX_OFFSET_DAC)
               begin
                  // double buffered: the code moves only on its own load
                  offset_dac_input <= data;
               end
               else if (cmd == `CMD_LOAD && idx == `IDX_OFFSET_DAC)
                  offset_dac_code <= offset_dac_input;
            end
            else
            begin
               for (n = 0; n < `CHAN_COUNT; n = n + 1)
               begin
                  if (hits(sel, idx, n[4:0]))
                  begin
                     case (cmd)
                        `CMD_WRITE_INPUT:
                           if (sel != `SEL_PAIR)
                              input_reg[n] <= data;
                        `CMD_LOAD:
                           output_reg[n] <= calibrate(input_reg[n],
                              gain_reg[n], cal_offset_reg[n]);
                        `CMD_WRITE_THROUGH:
                        begin
                           input_reg[n] <= data;
                           output_reg[n] <= calibrate(data, gain_reg[n],
                              cal_offset_reg[n]);
                        end
                        `CMD_WRITE_GAIN:
                           if (sel != `SEL_PAIR)
                              gain_reg[n] <= data;
                        `CMD_WRITE_CAL_OFFSET:
                           if (sel != `SEL_PAIR)
                              cal_offset_reg[n] <= data;
                        `CMD_READ_INPUT:
                           if (sel != `SEL_PAIR)
                           begin
                              readback_word <= {input_reg[n], 18'h00000};
                           end
                        default:
                           ;
                     endcase
                  end
               end
               if (cmd == `CMD_READ_INPUT && sel != `SEL_PAIR)
                  readback_load <= 1'b1;
            end
         end
      end
   end
   always @(posedge clk)
   begin
      if (!reset_n)
         monitor_code <= `RESET_CODE;
      else
         monitor_code <= output_reg[monitor_channel];
   end
endmodule

// ---- verification/dac_serial_update_control_monitor.sv ----
// concurrent checks on the serial converter control ports
`timescale 1ns/1ps
module dac_serial_update_control_monitor
(
   input wire clk,
   input wire reset_n,
   input wire sclk,
   input wire chip_select_n,
   input wire din,
   input wire spi_mode,
   input wire load_outputs_n,
   input wire device_reset_n,
   input wire [4:0] monitor_channel,
   input wire dout,
   input wire [13:0] monitor_code,
   input wire [13:0] offset_dac_code,
   input wire word_accepted,
   input wire framing_error
);
   // ==========================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_accept_pulse: assert property
      (word_accepted |=> !word_accepted)
      else $error("accept pulse longer than one cycle");
   a_accept_cs_high: assert property
      (word_accepted |-> chip_select_n && $past(chip_select_n, 2))
      else $error("accept while chip select low");
   a_dout_after_fall: assert property
      ($changed(dout) |-> !sclk)
      else $error("serial out moved while serial clock high");
   // own disable so the check is live while reset is held
   a_reset_clears: assert property
      (@(posedge clk) disable iff (1'b0) !reset_n |=>
      monitor_code == 14'h0000 && offset_dac_code == 14'h0000
      && !word_accepted && !framing_error)
      else $error("outputs not cleared by reset");
   a_devreset_clears: assert property
      (!device_reset_n [*7] |-> monitor_code == 14'h0000 &&
      offset_dac_code == 14'h0000)
      else $error("device reset left outputs set");
   a_sticky_error: assert property
      (device_reset_n [*5] ##0 framing_error |=> framing_error)
      else $error("framing error dropped");
   a_spi_no_error: assert property
      ($rose(framing_error) |-> !spi_mode)
      else $error("framing error in spi framing");
   a_offset_cause: assert property
      ($changed(offset_dac_code) |->
      word_accepted || $past(word_accepted) || !device_reset_n)
      else $error("offset code changed without command");
   c_accept: cover property (word_accepted);
   c_dsp_accept: cover property (word_accepted && !spi_mode);
   c_error: cover property ($rose(framing_error));
   c_load_pin: cover property (!load_outputs_n);
endmodule
bind dac_serial_update_control dac_serial_update_control_monitor i_mon
(
   .clk(clk), .reset_n(reset_n), .sclk(sclk), .chip_select_n(chip_select_n),
   .din(din), .spi_mode(spi_mode), .load_outputs_n(load_outputs_n),
   .device_reset_n(device_reset_n), .monitor_channel(monitor_channel),
   .dout(dout), .monitor_code(monitor_code),
   .offset_dac_code(offset_dac_code), .word_accepted(word_accepted),
   .framing_error(framing_error)
);

// ---- verification/host_serial_model.sv ----
// host serial port model: frames, serial clock and data line
`timescale 1ns/1ps
module host_serial_model
(
   input wire logic clk,
   output logic sclk,
   output logic chip_select_n,
   output logic din,
   input wire logic dout
);
   // ==========================================
   // frame generator; clock idles low between frames
   initial
   begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      din = 1'b0;
   end
   task automatic frame(input logic [31:0] w, input int n,
      output logic [31:0] q);
      q = 32'h0;
      // start off the clk edge grid so no pin moves as clk samples it
      @(posedge clk);
      #251 chip_select_n = 1'b0;
      #62.5;
      for (int i = 0; i < n; i++)
      begin
         din = w[31-i];
         sclk = 1'b1;
         q = {q[30:0], dout};
         #62.5 sclk = 1'b0;
         #62.5;
      end
      // released line shows no stale bit
      din = ~din;
      chip_select_n = 1'b1;
   endtask
endmodule

// ---- verification/dac_serial_update_control_bench.sv ----
// self-checking bench for the serial converter control block
`timescale 1ns/1ps
module dac_serial_update_control_bench;
   logic clk = 1'b0, reset_n = 1'b0, spi_mode = 1'b1, seen;
   logic load_outputs_n = 1'b1, device_reset_n = 1'b1;
   logic [4:0] monitor_channel = 5'h00;
   logic [31:0] q;
   wire sclk, chip_select_n, din, dout, word_accepted, framing_error;
   wire [13:0] monitor_code, offset_dac_code;
   int fails = 0, checks_done = 0;
   initial forever #5 clk = ~clk;
   host_serial_model i_host (.clk(clk), .sclk(sclk),
      .chip_select_n(chip_select_n), .din(din), .dout(dout));
   dac_serial_update_control i_dut (.clk(clk), .reset_n(reset_n),
      .sclk(sclk), .chip_select_n(chip_select_n), .din(din),
      .spi_mode(spi_mode), .load_outputs_n(load_outputs_n),
      .device_reset_n(device_reset_n), .monitor_channel(monitor_channel),
      .dout(dout), .monitor_code(monitor_code),
      .offset_dac_code(offset_dac_code), .word_accepted(word_accepted),
      .framing_error(framing_error));
   // ==========================================
   // helpers
   function logic [31:0] wd(logic [3:0] c, logic [5:0] t, logic [13:0] d);
      return {c, t, d, 8'h00};
   endfunction
   task check(input logic [13:0] got, input logic [13:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task send(input logic [31:0] w, input int n, output logic acc);
      i_host.frame(w, n, q);
      acc = 1'b0;
      repeat (12)
      begin
         @(posedge clk);
         #1 acc = acc | (word_accepted === 1'b1);
      end
   endtask
   // outputs are read 1 ns after the edge, once they have settled
   task look(input logic [4:0] ch, input logic [13:0] exp);
      @(posedge clk);
      #1 monitor_channel = ch;
      repeat (3) @(posedge clk);
      #1 check(monitor_code, exp);
   endtask
   // ==========================================
   // scenarios
   task t_write_load;
      send(wd(4'h1, 6'h05, 14'h1234), 32, seen);
      check({13'h0, seen}, 14'h1);
      look(5'd5, 14'h0000);
      send(wd(4'h2, 6'h3f, 14'h0000), 32, seen);
      look(5'd5, 14'h1234);
      // single-channel load must leave the other new input parked
      send(wd(4'h1, 6'h05, 14'h0055), 32, seen);
      send(wd(4'h1, 6'h16, 14'h0042), 32, seen);
      send(wd(4'h2, 6'h16, 14'h0000), 32, seen);
      look(5'd22, 14'h0042);
      look(5'd5, 14'h1234);
   endtask
   task t_targets;
      send(wd(4'h4, 6'h12, 14'h0abc), 32, seen);
      look(5'd18, 14'h0abc);
      send(wd(4'h4, 6'h23, 14'h2def), 32, seen);
      look(5'd3, 14'h2def);
      look(5'd19, 14'h2def);
   endtask
   task t_offset_dac;
      send(wd(4'h3, 6'h30, 14'h1555), 32, seen);
      send(wd(4'h2, 6'h30, 14'h0000), 32, seen);
      check(offset_dac_code, 14'h1555);
      send(wd(4'h3, 6'h30, 14'h0aaa), 32, seen);
      send(wd(4'h2, 6'h3f, 14'h0000), 32, seen);
      check(offset_dac_code, 14'h1555);
   endtask
   task t_refused;
      send(wd(4'h4, 6'h07, 14'h0111), 31, seen);
      check({13'h0, seen}, 14'h0);
      send(wd(4'h4, 6'h07, 14'h0222) | 32'hc0, 32, seen);
      look(5'd7, 14'h0000);
   endtask
   task t_calibrate;
      send(wd(4'h5, 6'h07, 14'h1000), 32, seen);
      send(wd(4'h6, 6'h07, 14'h0010), 32, seen);
      send(wd(4'h4, 6'h07, 14'h0100), 32, seen);
      look(5'd7, 14'h0190);
   endtask
   task t_hw_load;
      send(wd(4'h1, 6'h09, 14'h0777), 32, seen);
      @(posedge clk);
      #1 load_outputs_n = 1'b0;
      look(5'd9, 14'h0777);
      load_outputs_n = 1'b1;
      send(wd(4'h8, 6'h09, 14'h0000), 32, seen);
      i_host.frame(32'h0, 32, q);
      check(q[31:18], 14'h0777);
   endtask
   task t_dsp;
      @(posedge clk);
      #1 spi_mode = 1'b0;
      i_host.frame(wd(4'h4, 6'h0a, 14'h0333), 16, q);
      send(wd(4'h4, 6'h0a, 14'h0333) << 16, 16, seen);
      check({13'h0, seen}, 14'h1);
      look(5'd10, 14'h0333);
      send(32'h0, 20, seen);
      check({13'h0, framing_error}, 14'h1);
   endtask
   task t_dev_reset;
      @(posedge clk);
      #1 device_reset_n = 1'b0;
      repeat (8) @(posedge clk);
      #1 device_reset_n = 1'b1;
      look(5'd10, 14'h0000);
      check(offset_dac_code, 14'h0000);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      t_write_load;
      t_targets;
      t_offset_dac;
      t_refused;
      t_calibrate;
      t_hw_load;
      t_dsp;
      t_dev_reset;
      print_verdict;
   end
   // about four times the expected run
   initial
   begin
      #400000;
      fails++;
      print_verdict;
   end
endmodule
